// ### hdl/ssb_engine.sv
// Stream scan buffer engine: scan timing, sample capture, overflow handling and registers.
//
// Operation
// (R1) Small variant sustains 40 ksamples per second.
// (R2) Large variant sustains 100 ksamples per second.
// (R3) Each scan reads every listed address once.
// (R4) Listed channel kinds select in, out or both.
// (R5) Every streamed sample is sixteen bits wide.
// (R6) Wide sources: emit low half, latch high half.
// (R7) Holding register streamable, returns latest upper half.
// (R8) Settle programmed microseconds before non-first channels.
// (R9) Resolution selects conversion; indices 9-12 unsupported.
// (R10) Normal input range settings stay in force.
// (R11) Scan overlap stops stream with code 2942.
// (R12) Samples buffered on chip, at most 32768 bytes.
// (R13) Size: power of two, zero default, next stream.
// (R14) Capacity is size bytes divided by two; capped at FIFO_DEPTH samples.
// (R15) On overflow keep scanning, discard until emptied.
// (R16) Count and report whole discarded scans.
// (R17) Overflow too long ends stream with error.
// (R18) Host fills skipped samples with dummy values.
// (R19) Host gap recovery needs first channel never 0xFFFF.
// (R20) Host joins halves as low plus 65536 high.
// (R21) Constant-rate scan pulses, scanning until stopped.
// (R22) Only one stream session at a time.
// (R23) Active stream blocks command-response analog reads.
// (R24) First scan one period after enable.
// (R25) Overflow limit counted in scans from first discard.
// (R26) Non power-of-two size writes are rejected.
`timescale 1ns/1ps
module ssb_engine
  import ssb_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output wire logic [31:0] reg_rdata,
  output wire logic        reg_rvalid,
  output wire logic        src_req,
  output wire logic [15:0] src_addr,
  output wire logic [3:0]  src_res,
  output wire logic        src_dir_out,
  input  wire logic        src_ack,
  input  wire logic [31:0] src_data,
  input  wire logic        src_wide,
  output wire logic        stream_active
);

  // Shortest scan period per listed address for this variant.
  localparam logic [31:0] MIN_CYC = LARGE_VARIANT ? 32'(LARGE_MIN_CYC) : 32'(SMALL_MIN_CYC); // R1 R2

  typedef struct packed {
    logic         run;
    logic         refused;
    logic         has_in;
    logic         has_out;
    logic         discard;
    logic         scan_drop;
    ssb_phase_t   phase;
    logic [LIST_AW-1:0] idx;
    logic [4:0]   nadr;
    logic [3:0]   res;
    logic [LEVEL_W-1:0] cap;
    logic [15:0]  size_b;
    logic [15:0]  hold;
    logic [15:0]  err;
    logic [15:0]  drops;
    logic [15:0]  ovf_scans;
    logic [31:0]  settle_us;
    logic [31:0]  period;
    logic [31:0]  pcnt;
    logic [31:0]  scnt;
    logic [31:0]  rdata;
    logic         rvalid;
    logic         req;
    logic [15:0]  req_addr;
    logic         req_out;
  } ssb_state_t;

  ssb_state_t          s;
  ssb_state_t          n;
  logic                tick;
  logic                got;
  logic [SAMPLE_W-1:0] gval;
  logic                push;
  logic                pop;
  logic                flush;
  logic                scan_end;
  logic                list_we;
  logic                rate_ok;
  logic [31:0]         need_cyc;
  logic [15:0]         cap_bytes;
  logic [LEVEL_W-1:0]  cap_now;
  logic [15:0]         mem_q;
  logic [15:0]         src_upper;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [SAMPLE_W-1:0] fifo_out_data;
  logic [LEVEL_W-1:0]  fifo_level;

  // Every top output comes from the state register.
  assign reg_rdata     = s.rdata;
  assign reg_rvalid    = s.rvalid;
  assign src_req       = s.req;
  assign src_addr      = s.req_addr;
  assign src_dir_out   = s.req_out;
  assign src_res       = s.res;  // R10
  assign stream_active = s.run;  // R23
  assign src_upper     = src_data[31:16];

  // Scan list storage; the read address follows the current list position.
  ssb_list_mem #(
    .WIDTH (16),
    .DEPTH (LIST_DEPTH)
  ) u_list (
    .clk   (clk),
    .we    (list_we),
    .waddr (reg_addr[LIST_AW-1:0]),
    .wdata (reg_wdata[15:0]),
    .raddr (s.idx),
    .rdata (mem_q)
  );

  // Sample buffer between the scan engine and the host's data register.
  ssb_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (flush),
    .in_valid  (push),
    .in_data   (gval),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Buffer capacity in samples, limited by the physical FIFO depth.
  always_comb begin
    cap_bytes = (s.size_b == 16'h0) ? DEF_BUF_BYTES : s.size_b;  // R13
    if ((cap_bytes >> 1) >= 16'(FIFO_DEPTH)) begin  // R14 R12
      cap_now = LEVEL_W'(FIFO_DEPTH);
    end else begin
      cap_now = cap_bytes[LEVEL_W:1];
    end
  end

  // Multi-address lists at slow resolutions get twice the per-sample allowance.
  always_comb begin
    need_cyc = 32'(s.nadr) * MIN_CYC;  // R1 R2 R3
    if (s.nadr > 5'h1 && s.res > 4'h1) begin
      need_cyc = need_cyc << 1;
    end
    rate_ok = (s.nadr != 5'h0) && (s.period >= need_cyc);
  end

  // Next-state logic: scan clock, scan sequencing, overflow and registers.
  always_comb begin
    n        = s;
    n.req    = 1'b0;
    n.rvalid = 1'b0;
    tick     = 1'b0;
    got      = 1'b0;
    gval     = '0;
    push     = 1'b0;
    pop      = 1'b0;
    flush    = 1'b0;
    scan_end = 1'b0;
    list_we  = 1'b0;

    // Scan clock divider; the first pulse lands one full period after start.
    if (s.run) begin
      if (s.pcnt >= s.period - 32'h1) begin  // R21 R24
        tick   = 1'b1;
        n.pcnt = '0;
      end else begin
        n.pcnt = s.pcnt + 32'h1;
      end
    end

    unique case (s.phase)
      PH_IDLE: begin
        if (tick) begin
          n.phase = PH_FETCH;  // R21
          n.idx   = '0;
          // Storing resumes on a whole scan boundary once the host drained the buffer.
          if (s.discard && fifo_level == '0) begin  // R15
            n.discard   = 1'b0;
            n.scan_drop = 1'b0;
            n.ovf_scans = '0;  // R25
          end else begin
            n.scan_drop = s.discard;
          end
        end
      end
      PH_FETCH: begin
        // The first channel settles within the scan period itself.
        n.phase = PH_SETTLE;
        if (s.idx == '0) begin  // R8
          n.scnt = '0;
        end else if (s.settle_us == 32'h0) begin
          n.scnt = AUTO_SETTLE_CYC;  // R8
        end else begin
          n.scnt = 32'(s.settle_us * CYC_PER_US);  // R8
        end
      end
      PH_SETTLE: begin
        if (s.scnt != 32'h0) begin
          n.scnt = s.scnt - 32'h1;
        end else if (mem_q == A_HOLD) begin
          got  = 1'b1;
          gval = s.hold;  // R7
        end else begin
          n.req      = 1'b1;
          n.req_addr = mem_q;
          n.req_out  = ssb_is_out(mem_q);  // R4
          n.phase    = PH_SAMPLE;
        end
      end
      PH_SAMPLE: begin
        if (src_ack) begin
          got  = 1'b1;
          gval = src_data[15:0];  // R5 R6
          if (src_wide) begin
            n.hold = src_upper;  // R6
          end
        end
      end
    endcase

    // A finished sample either goes out, into the buffer, or is discarded.
    if (got) begin
      if (ssb_is_out(mem_q)) begin
        n.has_out = 1'b1;  // R4
      end else begin
        n.has_in = 1'b1;  // R4
        if (s.discard || fifo_level >= s.cap || !fifo_in_ready) begin  // R15
          n.discard   = 1'b1;
          n.scan_drop = 1'b1;
        end else begin
          push = 1'b1;
        end
      end
      if (5'(s.idx) + 5'h1 == s.nadr) begin  // R3
        scan_end = 1'b1;
        n.phase  = PH_IDLE;
      end else begin
        n.idx   = s.idx + 1'b1;
        n.phase = PH_FETCH;
      end
    end

    // Whole discarded scans are counted, and a long overflow ends the stream.
    if (scan_end && n.scan_drop) begin
      n.drops     = s.drops + 16'h1;  // R16
      n.ovf_scans = s.ovf_scans + 16'h1;
      if (n.ovf_scans >= OVF_SCANS_MAX) begin  // R17 R25
        n.run   = 1'b0;
        n.phase = PH_IDLE;
        n.err   = ERR_OVF_END;
      end
    end

    // A scan pulse arriving mid-scan means the rate is too high.
    if (tick && s.phase != PH_IDLE) begin  // R11
      n.run   = 1'b0;
      n.phase = PH_IDLE;
      n.err   = ERR_SCAN_OVERLAP;
    end

    // Register writes come last so that a stop from the host always wins.
    if (reg_wr) begin
      case (reg_addr)
        A_SETTLE: n.settle_us = reg_wdata;
        A_RES: begin
          if (reg_wdata <= 32'(RES_MAX_STREAM)) begin  // R9
            n.res = reg_wdata[3:0];
          end
        end
        A_BUFSZ: begin
          if (ssb_size_ok(reg_wdata)) begin  // R12 R13 R26
            n.size_b = reg_wdata[15:0];
          end
        end
        A_PERIOD: n.period = reg_wdata;
        A_NADR: begin
          if (!s.run && reg_wdata <= 32'(LIST_DEPTH)) begin
            n.nadr = reg_wdata[4:0];
          end
        end
        A_ENABLE: begin
          if (!reg_wdata[0]) begin
            n.run   = 1'b0;
            n.phase = PH_IDLE;
          end else if (!s.run) begin  // R22
            if (rate_ok) begin
              n.run       = 1'b1;
              n.refused   = 1'b0;
              n.pcnt      = '0;  // R24
              n.phase     = PH_IDLE;
              n.err       = ERR_NONE;
              n.drops     = '0;
              n.ovf_scans = '0;
              n.discard   = 1'b0;
              n.scan_drop = 1'b0;
              n.has_in    = 1'b0;
              n.has_out   = 1'b0;
              n.cap       = cap_now;  // R13
              flush       = 1'b1;
            end else begin
              n.refused = 1'b1;  // R1 R2
            end
          end
        end
        default: ;
      endcase
      // The scan list is frozen while a stream runs.
      if (reg_addr[15:LIST_AW] == A_LIST[15:LIST_AW] && !s.run) begin
        list_we = 1'b1;
      end
    end

    // Register reads answer one cycle later; the data register pops a sample.
    if (reg_rd) begin
      n.rvalid = 1'b1;
      n.rdata  = '0;
      case (reg_addr)
        A_SETTLE: n.rdata = s.settle_us;
        A_RES:    n.rdata[3:0] = s.res;
        A_BUFSZ:  n.rdata[15:0] = s.size_b;
        A_HOLD:   n.rdata[15:0] = s.hold;  // R7
        A_ENABLE: n.rdata[0] = s.run;
        A_PERIOD: n.rdata = s.period;
        A_NADR:   n.rdata[4:0] = s.nadr;
        A_STATUS: begin
          n.rdata[ST_RUN]     = s.run;
          n.rdata[ST_DISCARD] = s.discard;
          n.rdata[ST_IN]      = s.has_in;
          n.rdata[ST_OUT]     = s.has_out;
          n.rdata[ST_REFUSED] = s.refused;
        end
        A_ERROR:  n.rdata[15:0] = s.err;
        A_DROPS:  n.rdata[15:0] = s.drops;  // R16
        A_DATA: begin
          pop = fifo_out_valid;
          if (fifo_out_valid) begin
            n.rdata[15:0] = fifo_out_data;
          end
        end
        A_LEVEL:  n.rdata[LEVEL_W-1:0] = fifo_level;
        default:  n.rdata = '0;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Checks on the engine's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_scan_overlap_stop: assert property ( // R11
    tick && s.phase != PH_IDLE |=> !s.run && s.err == ERR_SCAN_OVERLAP)
    else $error("scan overlap did not stop the stream");

  chk_scan_pass_start: assert property ( // R21
    tick && s.phase == PH_IDLE && !(reg_wr && reg_addr == A_ENABLE) |=> s.phase == PH_FETCH && s.idx == '0)
    else $error("scan pulse did not start a pass at the first entry");

  chk_first_scan_delay: assert property ( // R24
    $rose(s.run) |-> (!tick && s.phase == PH_IDLE) [*8])
    else $error("scan started before one period elapsed");

  chk_res_reject: assert property ( // R9
    reg_wr && reg_addr == A_RES && reg_wdata >= 32'h9 && reg_wdata <= 32'hC |=> s.res == $past(s.res))
    else $error("unsupported resolution was accepted");

  chk_size_reject: assert property ( // R26
    reg_wr && reg_addr == A_BUFSZ && !ssb_size_ok(reg_wdata) |=> $stable(s.size_b))
    else $error("bad buffer size was accepted");

  chk_cap_frozen: assert property ( // R13
    s.run && !(reg_wr && reg_addr == A_ENABLE) |=> $stable(s.cap))
    else $error("buffer capacity changed during a stream");

  chk_upper_latch: assert property ( // R6
    s.phase == PH_SAMPLE && src_ack && src_wide |=> s.hold == $past(src_upper))
    else $error("upper half was not latched");

  chk_discard_no_push: assert property ( // R15
    s.discard |=> fifo_level <= $past(fifo_level))
    else $error("sample stored while discarding");

  chk_drop_count: assert property ( // R16
    scan_end && n.scan_drop |=> s.drops == $past(s.drops) + 16'h1)
    else $error("discarded scan not counted");

  chk_overflow_end: assert property ( // R17
    scan_end && n.scan_drop && !tick && s.ovf_scans == OVF_SCANS_MAX - 16'h1 |=> !s.run && s.err == ERR_OVF_END)
    else $error("long overflow did not end the stream");

  cov_overlap: cover property (tick && s.phase != PH_IDLE);
  cov_dropped_scan: cover property (scan_end && n.scan_drop);
  cov_wide_source: cover property (s.phase == PH_SAMPLE && src_ack && src_wide);

endmodule : ssb_engine

// ### shared/ssb_pkg.sv
// Shared constants, types and helper functions of the stream scan buffer engine.
package ssb_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int NS_PER_S      = 1000000000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;

  // Sustained total sample rate of each variant, in samples per second.
  localparam int SMALL_MAX_SPS = 40000;
  localparam int LARGE_MAX_SPS = 100000;
  localparam int SMALL_MIN_CYC = NS_PER_S / (SMALL_MAX_SPS * CLK_PERIOD_NS);
  localparam int LARGE_MIN_CYC = NS_PER_S / (LARGE_MAX_SPS * CLK_PERIOD_NS);

  // Settling used when the programmed settling time is below one microsecond.
  localparam logic [31:0] AUTO_SETTLE_CYC = 32'h0000_0032;

  // Register addresses on the host link.
  localparam logic [15:0] A_SETTLE = 16'h0FA8;
  localparam logic [15:0] A_RES    = 16'h0FAA;
  localparam logic [15:0] A_BUFSZ  = 16'h0FAC;
  localparam logic [15:0] A_HOLD   = 16'h1323;
  localparam logic [15:0] A_ENABLE = 16'h0FB0;
  localparam logic [15:0] A_PERIOD = 16'h0FB2;
  localparam logic [15:0] A_NADR   = 16'h0FB4;
  localparam logic [15:0] A_STATUS = 16'h0FB6;
  localparam logic [15:0] A_ERROR  = 16'h0FB8;
  localparam logic [15:0] A_DROPS  = 16'h0FBA;
  localparam logic [15:0] A_DATA   = 16'h0FBC;
  localparam logic [15:0] A_LEVEL  = 16'h0FBE;
  localparam logic [15:0] A_LIST   = 16'h0FC0;

  // Scan list entries whose upper address byte equals this are output channels.
  localparam logic [7:0] OUT_ADDR_HI = 8'h12;

  // Bit positions in the status register.
  localparam int ST_RUN     = 0;
  localparam int ST_DISCARD = 1;
  localparam int ST_IN      = 2;
  localparam int ST_OUT     = 3;
  localparam int ST_REFUSED = 4;

  // Error codes; the overflow end code is an arbitrary value.
  localparam logic [15:0] ERR_NONE         = 16'h0000;
  localparam logic [15:0] ERR_SCAN_OVERLAP = 16'h0B7E;
  localparam logic [15:0] ERR_OVF_END      = 16'h0B7F;

  // Buffer and list geometry.
  localparam int          SAMPLE_W       = 16;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          LEVEL_W        = 4;
  localparam int          LIST_DEPTH     = 16;
  localparam int          LIST_AW        = 4;
  localparam logic [31:0] MAX_BUF_BYTES  = 32'h0000_8000;
  localparam logic [15:0] DEF_BUF_BYTES  = 16'h0010;
  localparam logic [3:0]  RES_MAX_STREAM = 4'h8;
  localparam logic [15:0] OVF_SCANS_MAX  = 16'h0004;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_FETCH  = 2'b01,
    PH_SETTLE = 2'b10,
    PH_SAMPLE = 2'b11
  } ssb_phase_t;

  // True for an output-streamable scan list address.
  function automatic logic ssb_is_out(input logic [15:0] a);
    return a[15:8] == OUT_ADDR_HI;
  endfunction : ssb_is_out

  // True for an acceptable buffer size: zero or a power of two up to the maximum.
  function automatic logic ssb_size_ok(input logic [31:0] v);
    return (v == 32'h0) || ((v <= MAX_BUF_BYTES) && ((v & (v - 32'h1)) == 32'h0));
  endfunction : ssb_size_ok

endpackage : ssb_pkg

// ### hdl/ssb_fifo.sv
// Parameterised sample FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ssb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     flush,
  input  wire logic                     in_valid,
  input  wire logic [WIDTH-1:0]         in_data,
  output wire logic                     in_ready,
  output wire logic                     out_valid,
  input  wire logic                     out_ready,
  output wire logic [WIDTH-1:0]         out_data,
  output wire logic [$clog2(DEPTH):0]   level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } ssb_fifo_state_t;

  ssb_fifo_state_t s;
  ssb_fifo_state_t n;
  logic            do_push;
  logic            do_pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = s.cnt < (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data  = s.mem[s.rp];
  assign level     = s.cnt;
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_ready && out_valid;

  // Pointers wrap naturally because the depth is a power of two.
  always_comb begin
    n = s;
    if (flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end else begin
      if (do_push) begin
        n.mem[s.wp] = in_data;
        n.wp        = s.wp + 1'b1;
      end
      if (do_pop) begin
        n.rp = s.rp + 1'b1;
      end
      n.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : ssb_fifo

// ### hdl/ssb_list_mem.sv
// Scan list memory with one write port and a registered read port.
`timescale 1ns/1ps
module ssb_list_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output wire logic [WIDTH-1:0]         rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            q;
  } ssb_mem_state_t;

  ssb_mem_state_t s;
  ssb_mem_state_t n;

  assign rdata = s.q;

  // Read data is the word addressed in the previous cycle.
  always_comb begin
    n   = s;
    n.q = s.mem[raddr];
    if (we) begin
      n.mem[waddr] = wdata;
    end
  end

  // Contents need no reset; the engine only reads entries the host has written.
  always_ff @(posedge clk) begin
    s <= n;
  end
endmodule : ssb_list_mem

// ### sim/ssb_src_model.sv
// Behavioural sample source answering the engine's sample requests.
`timescale 1ns/1ps
module ssb_src_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        src_req,
  input  wire logic [15:0] src_addr,
  output logic             src_ack,
  output logic [31:0]      src_data,
  output logic             src_wide
);
  // One answer per request after one or six cycles; data is scrambled between answers so stale values never match.
  initial begin
    src_ack = 1'b0;
    src_data = 32'h0;
    src_wide = 1'b0;
    // Each signal gets one assignment per edge, so an answer never races its own clear.
    forever begin
      @(posedge clk);
      if (src_req === 1'b1) begin
        repeat (slow ? 5 : 0) @(posedge clk);
        src_ack <= 1'b1;
        src_wide <= src_addr[8];
        src_data <= {src_addr + 16'h1111, src_addr ^ 16'h00C3};
      end else begin
        src_ack <= 1'b0;
        src_data <= ~src_data;
      end
    end
  end
endmodule : ssb_src_model

// ### sim/stream_scan_buffer_engine_bench.sv
// Self-checking bench of the stream scan buffer engine.
`timescale 1ns/1ps
module stream_scan_buffer_engine_bench import ssb_pkg::*;;
  typedef struct packed {logic [15:0] a; logic [31:0] d; logic [31:0] e;} ssb_row_t;
  localparam int P = 3000;
  logic        clk, nrst, reg_wr, reg_rd, reg_rvalid, src_req, src_ack, src_wide, src_dir_out, stream_active, slow;
  logic [15:0] reg_addr, src_addr;
  logic [31:0] reg_wdata, reg_rdata, src_data;
  logic [3:0]  src_res;
  int          num_errors, compares, cyc, t0, n;
  logic [15:0] ra [5] = '{A_SETTLE, A_RES, A_BUFSZ, A_STATUS, A_DROPS};
  logic [31:0] ex [3] = '{32'h00C3, 32'h01C3, 32'h1211};
  logic [31:0] bad [2][2] = '{'{32'h2, 32'h176F}, '{32'h0, 32'h0BB7}};
  ssb_row_t    rows [7] = '{'{A_SETTLE, 32'h1, 32'h1}, '{A_RES, 32'h3, 32'h3}, '{A_RES, 32'h9, 32'h3},
                            '{A_RES, 32'h0, 32'h0}, '{A_BUFSZ, 32'h6, 32'h0}, '{A_BUFSZ, 32'h8, 32'h8},
                            '{16'h0100, 32'h5, 32'h0}};

  ssb_engine dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .src_req(src_req),
                    .src_addr(src_addr), .src_res(src_res), .src_dir_out(src_dir_out), .src_ack(src_ack),
                    .src_data(src_data), .src_wide(src_wide), .stream_active(stream_active));
  ssb_src_model src_u (.clk(clk), .slow(slow), .src_req(src_req), .src_addr(src_addr), .src_ack(src_ack),
                       .src_data(src_data), .src_wide(src_wide));

  // Clock at 100 MHz; the cycle counter times checks against the scan period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  // Bus tasks start and end just after a rising edge, so no strobe is assigned twice in one step.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata & m, e);
    @(posedge clk);
  endtask : rd

  // Counts cycles to the next sample request; gives up after two scan periods.
  task automatic wait_req(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (src_req !== 1'b1 && c < 2 * P);
    if (src_req !== 1'b1) begin
      num_errors++;
      $display("BAD %0t no sample request", $time);
      report_and_stop();
    end
  endtask : wait_req

  task automatic upto(input int k);
    do @(posedge clk); while (cyc < t0 + k);
  endtask : upto

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 32'h0;
    slow = 1'b0;
    num_errors = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values, then the register table rows.
    foreach (ra[i]) rd(ra[i], 32'h0);
    chk({31'h0, stream_active}, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // Scan list: plain input, wide source, holding register.
    wr(A_LIST, 32'h0);
    wr(A_LIST + 16'h1, 32'h0100);
    wr(A_LIST + 16'h2, {16'h0, A_HOLD});
    wr(A_NADR, 32'h3);
    // Starts above the sustained rate are refused.
    foreach (bad[i]) begin
      wr(A_RES, bad[i][0]);
      wr(A_PERIOD, bad[i][1]);
      wr(A_ENABLE, 32'h1);
      rd(A_STATUS, 32'h10, 32'h11);
    end
    wr(A_PERIOD, 32'(P));
    wr(A_ENABLE, 32'h1);
    t0 = cyc;
    wait_req(n);
    chk({n >= P && n <= P + 8, 10'h0, src_dir_out, src_res, src_addr}, 32'h8000_0000);
    wait_req(n);
    chk({n >= 100 && n <= 110, 15'h0, src_addr}, 32'h8000_0100);
    upto(P + 1500);
    rd(A_STATUS, 32'h5, 32'hF);
    chk({31'h0, stream_active}, 32'h1);
    wr(A_BUFSZ, 32'h10);
    // A second start while running must neither flush the buffer nor pick up the new size.
    wr(A_ENABLE, 32'h1);
    rd(A_LEVEL, 32'h3);
    foreach (ex[i]) rd(A_DATA, ex[i]);
    rd(A_HOLD, 32'h1211);
    // Capacity stays four samples; the third scan overflows.
    upto(3 * P + 1500);
    rd(A_LEVEL, 32'h4);
    rd(A_DROPS, 32'h1);
    rd(A_STATUS, 32'h7, 32'hF);
    for (int i = 0; i < 4; i++) rd(A_DATA, ex[i % 3]);
    upto(4 * P + 1500);
    rd(A_LEVEL, 32'h3);
    upto(7 * P + 1500);
    rd(A_STATUS, 32'h7, 32'hF);
    upto(8 * P + 1500);
    rd(A_ERROR, {16'h0, ERR_OVF_END});
    rd(A_DROPS, 32'h5);
    chk({31'h0, stream_active}, 32'h0);
    // Slow source and long settling make one scan outlast the period.
    wr(A_SETTLE, 32'h14);
    wr(A_LIST + 16'h1, 32'h1200);
    slow <= 1'b1;
    wr(A_ENABLE, 32'h1);
    t0 = cyc;
    rd(A_ERROR, 32'h0);
    rd(A_STATUS, 32'h1, 32'hF);
    upto(P + 2500);
    chk({15'h0, src_dir_out, src_addr}, 32'h0001_1200);
    rd(A_STATUS, 32'hD, 32'hF);
    upto(2 * P + 100);
    rd(A_ERROR, {16'h0, ERR_SCAN_OVERLAP});
    chk({31'h0, stream_active}, 32'h0);
    report_and_stop();
  end
endmodule : stream_scan_buffer_engine_bench
